// ---- rtl/dpmb_pkg.sv ----
package dpmb_pkg;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 36;
  localparam logic [DATA_W-1:0] WORD_RST = 36'h0_0000_0000;
  localparam logic FLAG_RST = 1'b1;
  localparam logic OE_N_RST = 1'b1;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Port A writes with write_read high, port B writes with it low
  // ----------------------------------------------------------------
  localparam logic PORT_A_WRITE_LEVEL = 1'b1;
  localparam logic PORT_B_WRITE_LEVEL = 1'b0;

  typedef struct packed {
    logic chip_select_n;
    logic write_read;
    logic enable;
    logic mail_select;
  } dpmb_port_ctl_t;

  localparam dpmb_port_ctl_t CTL_RST = 4'h8;

endpackage : dpmb_pkg

// ---- rtl/dpmb_mail_dir.sv ----
`timescale 1ns/10ps
module dpmb_mail_dir (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic dir_reset_n_i,
  input wire logic write_strobe_i,
  input wire logic read_strobe_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] write_data_i,
  output logic [dpmb_pkg::DATA_W-1:0] mail_word_o,
  output logic mail_flag_o
);

  logic [dpmb_pkg::DATA_W-1:0] word_reg;
  logic flag_reg;
  logic accept;

  // Flag low means unread mail; writes bounce off until it is read
  assign accept = write_strobe_i && flag_reg;

  // ----------------------------------------------------------------
  // Stored word
  // ----------------------------------------------------------------
  // Word survives the direction reset; only the flag is forced
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      word_reg <= dpmb_pkg::WORD_RST;
    end else if (accept) begin
      word_reg <= write_data_i;
    end
  end

  // ----------------------------------------------------------------
  // Mail flag
  // ----------------------------------------------------------------
  // Accepted write beats a read in the same cycle so no mail is lost
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !dir_reset_n_i) begin
      flag_reg <= dpmb_pkg::FLAG_RST;
    end else if (accept) begin
      flag_reg <= 1'b0;
    end else if (read_strobe_i) begin
      flag_reg <= 1'b1;
    end
  end

  assign mail_word_o = word_reg;
  assign mail_flag_o = flag_reg;

endmodule : dpmb_mail_dir

// ---- rtl/dpmb_top.sv ----
`timescale 1ns/10ps
module dpmb_top (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic port_a_clock_i,
  input wire logic port_b_clock_i,
  input wire dpmb_pkg::dpmb_port_ctl_t port_a_ctl_i,
  input wire dpmb_pkg::dpmb_port_ctl_t port_b_ctl_i,
  input wire logic direction_one_reset_n_i,
  input wire logic direction_two_reset_n_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] port_a_data_bus_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] port_b_data_bus_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] queue_a_out_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] queue_b_out_i,
  output logic [dpmb_pkg::DATA_W-1:0] port_a_data_bus_o,
  output logic [dpmb_pkg::DATA_W-1:0] port_b_data_bus_o,
  output logic port_a_data_oe_n_o,
  output logic port_b_data_oe_n_o,
  output logic a_to_b_mail_flag_o,
  output logic b_to_a_mail_flag_o
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic port_active(input dpmb_pkg::dpmb_port_ctl_t ctl);
    port_active = ctl.enable && !ctl.chip_select_n;
  endfunction : port_active

  function automatic logic is_write(input dpmb_pkg::dpmb_port_ctl_t ctl,
                                    input logic write_level);
    is_write = (ctl.write_read == write_level);
  endfunction : is_write

  // Read direction with chip select low; enable is not needed to drive
  function automatic logic drives_bus(input dpmb_pkg::dpmb_port_ctl_t ctl,
                                      input logic write_level);
    drives_bus = !ctl.chip_select_n && !is_write(ctl, write_level);
  endfunction : drives_bus

  // Mail select picks the opposite-direction word over the queue word
  function automatic logic [dpmb_pkg::DATA_W-1:0] read_word(
    input dpmb_pkg::dpmb_port_ctl_t ctl,
    input logic [dpmb_pkg::DATA_W-1:0] mail_word,
    input logic [dpmb_pkg::DATA_W-1:0] queue_word
  );
    read_word = ctl.mail_select ? mail_word : queue_word;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Two stages before any logic; stage one feeds stage two only
  logic clk_a_s1_reg;
  logic clk_a_s2_reg;
  logic clk_a_s3_reg;
  logic clk_b_s1_reg;
  logic clk_b_s2_reg;
  logic clk_b_s3_reg;
  dpmb_pkg::dpmb_port_ctl_t ctl_a_s1_reg;
  dpmb_pkg::dpmb_port_ctl_t ctl_a_s2_reg;
  dpmb_pkg::dpmb_port_ctl_t ctl_b_s1_reg;
  dpmb_pkg::dpmb_port_ctl_t ctl_b_s2_reg;
  logic [1:0] dir_rst_s1_reg;
  logic [1:0] dir_rst_s2_reg;
  logic [dpmb_pkg::DATA_W-1:0] data_a_s1_reg;
  logic [dpmb_pkg::DATA_W-1:0] data_a_s2_reg;
  logic [dpmb_pkg::DATA_W-1:0] data_b_s1_reg;
  logic [dpmb_pkg::DATA_W-1:0] data_b_s2_reg;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      clk_a_s1_reg <= 1'b0;
      clk_a_s2_reg <= 1'b0;
      clk_a_s3_reg <= 1'b0;
      clk_b_s1_reg <= 1'b0;
      clk_b_s2_reg <= 1'b0;
      clk_b_s3_reg <= 1'b0;
    end else begin
      clk_a_s1_reg <= port_a_clock_i;
      clk_a_s2_reg <= clk_a_s1_reg;
      clk_a_s3_reg <= clk_a_s2_reg;
      clk_b_s1_reg <= port_b_clock_i;
      clk_b_s2_reg <= clk_b_s1_reg;
      clk_b_s3_reg <= clk_b_s2_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctl_a_s1_reg <= dpmb_pkg::CTL_RST;
      ctl_a_s2_reg <= dpmb_pkg::CTL_RST;
      ctl_b_s1_reg <= dpmb_pkg::CTL_RST;
      ctl_b_s2_reg <= dpmb_pkg::CTL_RST;
      dir_rst_s1_reg <= 2'h3;
      dir_rst_s2_reg <= 2'h3;
    end else begin
      ctl_a_s1_reg <= port_a_ctl_i;
      ctl_a_s2_reg <= ctl_a_s1_reg;
      ctl_b_s1_reg <= port_b_ctl_i;
      ctl_b_s2_reg <= ctl_b_s1_reg;
      dir_rst_s1_reg <= {direction_two_reset_n_i, direction_one_reset_n_i};
      dir_rst_s2_reg <= dir_rst_s1_reg;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      data_a_s1_reg <= dpmb_pkg::WORD_RST;
      data_a_s2_reg <= dpmb_pkg::WORD_RST;
      data_b_s1_reg <= dpmb_pkg::WORD_RST;
      data_b_s2_reg <= dpmb_pkg::WORD_RST;
    end else begin
      data_a_s1_reg <= port_a_data_bus_i;
      data_a_s2_reg <= data_a_s1_reg;
      data_b_s1_reg <= port_b_data_bus_i;
      data_b_s2_reg <= data_b_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // Port edge strobes
  // ----------------------------------------------------------------
  // Port clocks must be well under half of sys_clk to be seen
  logic rise_a;
  logic rise_b;
  logic a_mail_op;
  logic b_mail_op;
  logic a_mail_write;
  logic b_mail_write;
  logic a_mail_read;
  logic b_mail_read;

  assign rise_a = clk_a_s2_reg && !clk_a_s3_reg;
  assign rise_b = clk_b_s2_reg && !clk_b_s3_reg;
  assign a_mail_op = rise_a && port_active(ctl_a_s2_reg) && ctl_a_s2_reg.mail_select;
  assign b_mail_op = rise_b && port_active(ctl_b_s2_reg) && ctl_b_s2_reg.mail_select;
  assign a_mail_write = a_mail_op && is_write(ctl_a_s2_reg, dpmb_pkg::PORT_A_WRITE_LEVEL);
  assign b_mail_write = b_mail_op && is_write(ctl_b_s2_reg, dpmb_pkg::PORT_B_WRITE_LEVEL);
  assign a_mail_read = a_mail_op && !is_write(ctl_a_s2_reg, dpmb_pkg::PORT_A_WRITE_LEVEL);
  assign b_mail_read = b_mail_op && !is_write(ctl_b_s2_reg, dpmb_pkg::PORT_B_WRITE_LEVEL);

  // ----------------------------------------------------------------
  // Mailboxes
  // ----------------------------------------------------------------
  logic [dpmb_pkg::DATA_W-1:0] a_to_b_word;
  logic [dpmb_pkg::DATA_W-1:0] b_to_a_word;

  dpmb_mail_dir u_a_to_b (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .dir_reset_n_i(dir_rst_s2_reg[0]),
    .write_strobe_i(a_mail_write),
    .read_strobe_i(b_mail_read),
    .write_data_i(data_a_s2_reg),
    .mail_word_o(a_to_b_word),
    .mail_flag_o(a_to_b_mail_flag_o)
  );

  dpmb_mail_dir u_b_to_a (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .dir_reset_n_i(dir_rst_s2_reg[1]),
    .write_strobe_i(b_mail_write),
    .read_strobe_i(a_mail_read),
    .write_data_i(data_b_s2_reg),
    .mail_word_o(b_to_a_word),
    .mail_flag_o(b_to_a_mail_flag_o)
  );

  // ----------------------------------------------------------------
  // Read data path
  // ----------------------------------------------------------------
  // Data is registered, so it trails the select by one sys_clk
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      port_a_data_bus_o <= dpmb_pkg::WORD_RST;
    end else begin
      port_a_data_bus_o <= read_word(ctl_a_s2_reg, b_to_a_word, queue_a_out_i);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      port_b_data_bus_o <= dpmb_pkg::WORD_RST;
    end else begin
      port_b_data_bus_o <= read_word(ctl_b_s2_reg, a_to_b_word, queue_b_out_i);
    end
  end

  // ----------------------------------------------------------------
  // Output enables
  // ----------------------------------------------------------------
  // Drive while selected for reading; enable not needed to drive
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      port_a_data_oe_n_o <= dpmb_pkg::OE_N_RST;
    end else begin
      port_a_data_oe_n_o <= !drives_bus(ctl_a_s2_reg, dpmb_pkg::PORT_A_WRITE_LEVEL);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      port_b_data_oe_n_o <= dpmb_pkg::OE_N_RST;
    end else begin
      port_b_data_oe_n_o <= !drives_bus(ctl_b_s2_reg, dpmb_pkg::PORT_B_WRITE_LEVEL);
    end
  end

endmodule : dpmb_top

// ---- bench/dpmb_monitor.sv ----
`timescale 1ns/10ps
module dpmb_monitor (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic port_a_clock_i,
  input wire logic port_b_clock_i,
  input wire dpmb_pkg::dpmb_port_ctl_t port_a_ctl_i,
  input wire dpmb_pkg::dpmb_port_ctl_t port_b_ctl_i,
  input wire logic direction_two_reset_n_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] queue_a_out_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] port_a_data_bus_o,
  input wire logic port_a_data_oe_n_o,
  input wire logic port_b_data_oe_n_o,
  input wire logic a_to_b_mail_flag_o,
  input wire logic b_to_a_mail_flag_o
);
  // ----------------------------------------
  // Codes {chip_select_n, write_read, enable, mail_select}
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence s_a_rise;
    $rose(port_a_clock_i);
  endsequence
  sequence s_b_rise;
    $rose(port_b_clock_i);
  endsequence
  property p_a_wr;
    s_a_rise ##0 port_a_ctl_i == 4'h7 && a_to_b_mail_flag_o |-> ##3 !a_to_b_mail_flag_o;
  endproperty
  property p_b_wr;
    s_b_rise ##0 port_b_ctl_i == 4'h3 && b_to_a_mail_flag_o |-> ##3 !b_to_a_mail_flag_o;
  endproperty
  property p_b_rd;
    s_b_rise ##0 port_b_ctl_i == 4'h7 |-> ##3 a_to_b_mail_flag_o;
  endproperty
  property p_a_rd;
    s_a_rise ##0 port_a_ctl_i == 4'h3 |-> ##3 b_to_a_mail_flag_o;
  endproperty
  property p_ab_fall;
    $fell(a_to_b_mail_flag_o) |-> $past(port_a_clock_i, 3) && $past(port_a_ctl_i, 3) == 4'h7;
  endproperty
  property p_ba_rise;
    $rose(b_to_a_mail_flag_o) |->
      !$past(direction_two_reset_n_i, 3) || $past(port_a_ctl_i, 3) == 4'h3;
  endproperty
  // Sync plus output register makes three edges of latency
  property p_a_queue;
    (port_a_ctl_i == 4'h2 && $stable(queue_a_out_i)) [*4] |-> port_a_data_bus_o == queue_a_out_i;
  endproperty
  property p_b_oe;
    (port_b_ctl_i == 4'h7) [*4] |-> !port_b_data_oe_n_o;
  endproperty
  property p_a_oe;
    (port_a_ctl_i == 4'h3) [*4] |-> !port_a_data_oe_n_o;
  endproperty
  a_a_wr: assert property (p_a_wr) else $error("a write did not fill");
  a_b_wr: assert property (p_b_wr) else $error("b write did not fill");
  a_b_rd: assert property (p_b_rd) else $error("b read did not empty");
  a_a_rd: assert property (p_a_rd) else $error("a read did not empty");
  a_ab_fall: assert property (p_ab_fall) else $error("flag fell without write");
  a_ba_rise: assert property (p_ba_rise) else $error("flag rose without cause");
  a_a_queue: assert property (p_a_queue) else $error("queue word not shown");
  a_b_oe: assert property (p_b_oe) else $error("read not driven");
  a_a_oe: assert property (p_a_oe) else $error("a read not driven");
endmodule : dpmb_monitor

bind dpmb_top dpmb_monitor u_mon (.sys_clk_i, .rst_n_i, .port_a_clock_i, .port_b_clock_i,
  .port_a_ctl_i, .port_b_ctl_i, .direction_two_reset_n_i, .queue_a_out_i, .port_a_data_bus_o,
  .port_a_data_oe_n_o, .port_b_data_oe_n_o, .a_to_b_mail_flag_o, .b_to_a_mail_flag_o);

// ---- bench/dpmb_port_model.sv ----
`timescale 1ns/10ps
module dpmb_port_model #(
  parameter logic WR_LVL = 1'b1
) (
  input wire logic sys_clk_i,
  input wire logic [dpmb_pkg::DATA_W-1:0] rd_data_i,
  output logic port_clock_o,
  output dpmb_pkg::dpmb_port_ctl_t ctl_o,
  output logic [dpmb_pkg::DATA_W-1:0] data_o
);
  initial begin
    port_clock_o = 1'b0;
    ctl_o = dpmb_pkg::CTL_RST;
    data_o = 36'h0_0000_0000;
  end
  // Port clock stands low between transfers; 4 sys_clk per phase
  task automatic xfer(input logic wr, input logic ms, input logic en, input logic csn,
                      input logic [dpmb_pkg::DATA_W-1:0] d,
                      output logic [dpmb_pkg::DATA_W-1:0] q);
    ctl_o.chip_select_n <= csn;
    ctl_o.write_read <= wr ? WR_LVL : ~WR_LVL;
    ctl_o.enable <= en;
    ctl_o.mail_select <= ms;
    data_o <= d;
    repeat (4) @(posedge sys_clk_i);
    port_clock_o <= 1'b1;
    repeat (4) @(posedge sys_clk_i);
    q = rd_data_i;
    port_clock_o <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    ctl_o <= dpmb_pkg::CTL_RST;
    // Released bus must not keep the old word
    data_o <= ~d;
    @(posedge sys_clk_i);
  endtask : xfer
endmodule : dpmb_port_model

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
  localparam int W = dpmb_pkg::DATA_W;
  localparam logic [W-1:0] HI = 36'h0_0000_0001;
  localparam logic [W-1:0] LO = 36'h0_0000_0000;
  localparam logic [W-1:0] D1 = 36'hA_5C3F_0E91;
  localparam logic [W-1:0] D2 = 36'h5_A3C0_F16E;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic direction_one_reset_n_i = 1'b1;
  logic direction_two_reset_n_i = 1'b1;
  logic [W-1:0] queue_a_out_i = 36'h1_2345_6789;
  logic [W-1:0] queue_b_out_i = 36'h9_8765_4321;
  logic port_a_clock_i, port_b_clock_i, port_a_data_oe_n_o, port_b_data_oe_n_o;
  logic a_to_b_mail_flag_o, b_to_a_mail_flag_o;
  dpmb_pkg::dpmb_port_ctl_t port_a_ctl_i, port_b_ctl_i;
  logic [W-1:0] port_a_data_bus_i, port_b_data_bus_i, port_a_data_bus_o, port_b_data_bus_o, rd;
  int fails = 0;
  int n_compared = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  dpmb_top DUT (.sys_clk_i, .rst_n_i, .port_a_clock_i, .port_b_clock_i, .port_a_ctl_i,
    .port_b_ctl_i, .direction_one_reset_n_i, .direction_two_reset_n_i, .port_a_data_bus_i,
    .port_b_data_bus_i, .queue_a_out_i, .queue_b_out_i, .port_a_data_bus_o, .port_b_data_bus_o,
    .port_a_data_oe_n_o, .port_b_data_oe_n_o, .a_to_b_mail_flag_o, .b_to_a_mail_flag_o);
  dpmb_port_model #(.WR_LVL(dpmb_pkg::PORT_A_WRITE_LEVEL)) u_pa (.sys_clk_i,
    .rd_data_i(port_a_data_bus_o), .port_clock_o(port_a_clock_i), .ctl_o(port_a_ctl_i),
    .data_o(port_a_data_bus_i));
  dpmb_port_model #(.WR_LVL(dpmb_pkg::PORT_B_WRITE_LEVEL)) u_pb (.sys_clk_i,
    .rd_data_i(port_b_data_bus_o), .port_clock_o(port_b_clock_i), .ctl_o(port_b_ctl_i),
    .data_o(port_b_data_bus_i));
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (1000) @(posedge sys_clk_i);
    fails++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    chk(W'(a_to_b_mail_flag_o), HI);
    chk(W'(port_a_data_oe_n_o), HI);
    $display("test reset done");
    u_pa.xfer(1'b1, 1'b1, 1'b1, 1'b0, D1, rd);
    chk(W'(a_to_b_mail_flag_o), LO);
    u_pa.xfer(1'b1, 1'b1, 1'b1, 1'b0, D2, rd);
    u_pb.xfer(1'b0, 1'b1, 1'b1, 1'b0, D2, rd);
    chk(rd, D1);
    chk(W'(a_to_b_mail_flag_o), HI);
    u_pb.xfer(1'b0, 1'b1, 1'b1, 1'b0, D2, rd);
    chk(rd, D1);
    u_pb.xfer(1'b1, 1'b1, 1'b1, 1'b0, D2, rd);
    chk(W'(b_to_a_mail_flag_o), LO);
    u_pa.xfer(1'b0, 1'b1, 1'b1, 1'b0, D1, rd);
    chk(rd, D2);
    chk(W'(b_to_a_mail_flag_o), HI);
    $display("test mail done");
    for (int i = 0; i < 3; i++) begin
      u_pa.xfer(1'b1, i != 2, i != 0, i == 1, D2, rd);
      chk(W'(a_to_b_mail_flag_o), HI);
    end
    u_pa.xfer(1'b0, 1'b0, 1'b1, 1'b0, D2, rd);
    chk(rd, queue_a_out_i);
    u_pb.xfer(1'b0, 1'b0, 1'b1, 1'b0, D2, rd);
    chk(rd, queue_b_out_i);
    $display("test qualify done");
    u_pa.xfer(1'b1, 1'b1, 1'b1, 1'b0, D2, rd);
    u_pb.xfer(1'b1, 1'b1, 1'b1, 1'b0, D1, rd);
    direction_one_reset_n_i <= 1'b0;
    direction_two_reset_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    direction_one_reset_n_i <= 1'b1;
    direction_two_reset_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    chk(W'(a_to_b_mail_flag_o), HI);
    chk(W'(b_to_a_mail_flag_o), HI);
    u_pb.xfer(1'b0, 1'b1, 1'b1, 1'b0, D1, rd);
    chk(rd, D2);
    $display("test direction reset done");
    end_of_test();
  end
endmodule : tb
